// ---- rtl/uart_line_status_flags.v ----
// Purpose: Line-status flags of a serial transceiver with its holding registers and FIFOs
// Assumes: Serializer raises txShiftBusy the cycle after txLoad; deserializer pulses rxValid
// Notes: APB slave with one wait state; line status read has side effects
//
// How it works
// - Error summary bit 7 set when an errored character enters the receive FIFO
// - Reading line status clears the error summary; it is 0 with no error
// - Bit 6 is 1 only when holding and shift registers are both empty
// - Bit 6 is 0 while holding or shift register holds a character
// - In FIFO mode bit 6 needs transmit FIFO and shift register empty
// - Character mode: bit 5 rises when the character moves to the shifter
// - Character mode: bit 5 falls with the host write to the holding register
// - FIFO mode: bit 5 set while transmit FIFO empty, cleared by one written byte
// - Holding-empty raises an interrupt when its enable is set
// - Bit 4 set when receive line stays low a full frame
// - FIFO mode loads just one break character however long the break lasts
// - Bit 3 set when a character lacks a valid stop bit
// - FIFO mode reports framing status of the character at the FIFO top
// - Bit 2 parity error, tied to the FIFO top character in FIFO mode
// - Bit 1 overrun when a character arrives with FIFO full; character dropped
// - Bit 0 set while any received character is held
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "uart_lsr_consts.vh"

module uart_line_status_flags (
    input wire sysClk,              // 40 MHz clock
    input wire sysRst,              // Async reset, active high
    input wire [7:0] paddr,         // APB address
    input wire psel,                // APB select
    input wire penable,             // APB enable
    input wire pwrite,              // APB direction
    input wire [31:0] pwdata,       // APB write data
    output reg [31:0] prdata,       // APB read data
    output wire pready,             // APB ready
    output reg pslverr,             // APB error on unmapped address
    output wire irq,                // Level interrupt
    output reg txLoad,              // Pulse: character to shifter
    output reg [7:0] txData,        // Character for shifter
    input wire txShiftBusy,         // Shift register holds a character
    input wire rxValid,             // Pulse: character assembled
    input wire [7:0] rxData,        // Received character
    input wire rxParityErr,         // Parity wrong on this character
    input wire rxFrameErr,          // Stop bit missing on this character
    input wire rxBreak,             // Line low for a whole frame
    input wire rxLine               // Serial input level
);

    reg [7:0] control;
    reg [2:0] irqMask;
    reg [2:0] irqStatus;
    reg accDone;
    reg [7:0] txMem [0:31];
    reg [4:0] txWr;
    reg [4:0] txRd;
    reg [5:0] txCount;
    reg [10:0] rxMem [0:31];
    reg [4:0] rxWr;
    reg [4:0] rxRd;
    reg [5:0] rxCount;
    reg overflow;
    reg errSummary;
    reg breakLoaded;
    reg holdEmptyPrev;
    reg fifoEnPrev;

    wire fifoEn = control[`CTRL_FIFO_EN];
    wire firstAcc = psel & penable & ~accDone;
    wire lastAcc = psel & penable & accDone;
    wire rdLs = firstAcc & ~pwrite & (paddr == `ADDR_LINE_STATUS);
    wire rdData = firstAcc & ~pwrite & (paddr == `ADDR_DATA);
    wire wrData = lastAcc & pwrite & (paddr == `ADDR_DATA);
    wire wrIrq = lastAcc & pwrite & (paddr == `ADDR_IRQ_STATUS);
    wire modeFlip = fifoEn != fifoEnPrev;

    function full;
        input [5:0] count;
        input en;
        begin
            full = en ? (count == `FIFO_DEPTH) : (count == `CHAR_DEPTH);
        end
    endfunction

    // Transmit side
    wire txPush = wrData & ~full(txCount, fifoEn);
    wire txPop = (txCount != 6'd0) & ~txShiftBusy & ~txLoad;

    // Receive side; in FIFO mode a held break suppresses repeats until the line recovers
    wire isBreakRepeat = rxBreak & breakLoaded & fifoEn;
    wire rxAccept = rxValid & ~isBreakRepeat;
    wire rxFull = full(rxCount, fifoEn);
    wire rxPush = rxAccept & ~rxFull;
    wire rxPop = rdData & (rxCount != 6'd0);
    wire rxErrChar = rxParityErr | rxFrameErr | rxBreak;

    wire [10:0] rxTop = rxMem[rxRd];
    wire rxHas = rxCount != 6'd0;

    wire holdEmpty = txCount == 6'd0;
    // fifo case
    // Load cycle counts as full: busy only rises one cycle later
    wire allEmpty = holdEmpty & ~txShiftBusy & ~txLoad;

    wire [7:0] lineStatus;
    assign lineStatus[`LS_RX_AVAILABLE] = rxHas;
    assign lineStatus[`LS_RX_OVERFLOW] = overflow;
    assign lineStatus[`LS_PARITY_FAULT] = rxHas & rxTop[8];
    assign lineStatus[`LS_STOP_BIT_ERROR] = rxHas & rxTop[9];
    assign lineStatus[`LS_BREAK_SEEN] = rxHas & rxTop[10];
    assign lineStatus[`LS_TX_HOLDING_EMPTY] = holdEmpty;
    assign lineStatus[`LS_TX_ALL_EMPTY] = allEmpty;
    assign lineStatus[`LS_FIFO_ERROR_SUMMARY] = errSummary;

    assign pready = accDone;
    assign irq = |(irqStatus & irqMask);

    // APB: data and side effects at first access edge, ready one cycle later
    always @(posedge sysClk or posedge sysRst) begin
        if (sysRst) begin
            accDone <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (firstAcc) begin
            accDone <= 1'b1;
            pslverr <= 1'b0;
            if (paddr == `ADDR_DATA) begin
                prdata <= {24'h00_0000, rxTop[7:0]};
            end else if (paddr == `ADDR_CONTROL) begin
                prdata <= {24'h00_0000, control};
            end else if (paddr == `ADDR_LINE_STATUS) begin
                prdata <= {24'h00_0000, lineStatus};
            end else if (paddr == `ADDR_IRQ_STATUS) begin
                prdata <= {29'h0000_0000, irqStatus};
            end else if (paddr == `ADDR_IRQ_MASK) begin
                prdata <= {29'h0000_0000, irqMask};
            end else begin
                prdata <= 32'h0000_0000;
                pslverr <= 1'b1;
            end
        end else if (lastAcc) begin
            accDone <= 1'b0;
        end
    end

    // Writable registers, taking effect at the ready edge
    always @(posedge sysClk or posedge sysRst) begin
        if (sysRst) begin
            control <= `RST_CONTROL;
            irqMask <= `RST_IRQ_MASK;
            fifoEnPrev <= 1'b0;
        end else begin
            fifoEnPrev <= fifoEn;
            if (lastAcc & pwrite) begin
                if (paddr == `ADDR_CONTROL) begin
                    control <= pwdata[7:0];
                end else if (paddr == `ADDR_IRQ_MASK) begin
                    irqMask <= pwdata[2:0];
                end
            end
        end
    end

    // Transmit holding register or FIFO; a mode change flushes it
    always @(posedge sysClk or posedge sysRst) begin
        if (sysRst) begin
            txWr <= 5'd0;
            txRd <= 5'd0;
            txCount <= 6'd0;
            txLoad <= 1'b0;
            txData <= 8'h00;
        end else if (modeFlip) begin
            txWr <= 5'd0;
            txRd <= 5'd0;
            txCount <= 6'd0;
            txLoad <= 1'b0;
        end else begin
            txLoad <= txPop;
            if (txPush) begin
                txMem[txWr] <= pwdata[7:0];
                txWr <= txWr + 5'd1;
            end
            if (txPop) begin
                txData <= txMem[txRd];
                txRd <= txRd + 5'd1;
            end
            if (txPush & ~txPop) begin
                txCount <= txCount + 6'd1;
            end else if (txPop & ~txPush) begin
                txCount <= txCount - 6'd1;
            end
        end
    end

    // Receive holding register or FIFO with per-character error tags
    always @(posedge sysClk or posedge sysRst) begin
        if (sysRst) begin
            rxWr <= 5'd0;
            rxRd <= 5'd0;
            rxCount <= 6'd0;
            breakLoaded <= 1'b0;
        end else if (modeFlip) begin
            rxWr <= 5'd0;
            rxRd <= 5'd0;
            rxCount <= 6'd0;
            breakLoaded <= 1'b0;
        end else begin
            if (rxLine) begin
                breakLoaded <= 1'b0;
            end else if (rxPush & rxBreak) begin
                breakLoaded <= 1'b1;
            end
            if (rxPush) begin
                rxMem[rxWr] <= {rxBreak, rxFrameErr, rxParityErr, rxData};
                rxWr <= rxWr + 5'd1;
            end
            if (rxPop) begin
                rxRd <= rxRd + 5'd1;
            end
            if (rxPush & ~rxPop) begin
                rxCount <= rxCount + 6'd1;
            end else if (rxPop & ~rxPush) begin
                rxCount <= rxCount - 6'd1;
            end
        end
    end

    // Sticky line flags; a new event beats the read clear
    always @(posedge sysClk or posedge sysRst) begin
        if (sysRst) begin
            overflow <= 1'b0;
            errSummary <= 1'b0;
        end else begin
            if (rxAccept & rxFull) begin
                overflow <= 1'b1;
            end else if (rdLs) begin
                overflow <= 1'b0;
            end
            if (fifoEn & rxPush & rxErrChar) begin
                errSummary <= 1'b1;
            end else if (rdLs) begin
                errSummary <= 1'b0;
            end
        end
    end

    // Interrupt status, write one to clear, set wins
    always @(posedge sysClk or posedge sysRst) begin
        if (sysRst) begin
            irqStatus <= 3'h0;
            holdEmptyPrev <= 1'b1;
        end else begin
            holdEmptyPrev <= holdEmpty;
            irqStatus[`IRQ_TX_HOLDING_EMPTY] <= (holdEmpty & ~holdEmptyPrev) |
                (irqStatus[`IRQ_TX_HOLDING_EMPTY] & ~(wrIrq & pwdata[`IRQ_TX_HOLDING_EMPTY]));
            irqStatus[`IRQ_LINE_ERROR] <= (rxAccept & rxFull) | (rxPush & rxErrChar) |
                (irqStatus[`IRQ_LINE_ERROR] & ~(wrIrq & pwdata[`IRQ_LINE_ERROR]));
            irqStatus[`IRQ_RX_DATA] <= rxPush |
                (irqStatus[`IRQ_RX_DATA] & ~(wrIrq & pwdata[`IRQ_RX_DATA]));
        end
    end

endmodule // uart_line_status_flags

// ---- pkg/uart_lsr_consts.vh ----
// Purpose: Constants of the line-status block: offsets, bit positions, reset values, depth
// Assumes: Included by bare name from rtl/
// Notes: Offsets are byte addresses on the APB word grid
`ifndef UART_LSR_CONSTS_VH
`define UART_LSR_CONSTS_VH

`define ADDR_DATA 8'h00
`define ADDR_CONTROL 8'h04
`define ADDR_LINE_STATUS 8'h08
`define ADDR_IRQ_STATUS 8'h0c
`define ADDR_IRQ_MASK 8'h10

`define CTRL_FIFO_EN 0

`define LS_RX_AVAILABLE 0
`define LS_RX_OVERFLOW 1
`define LS_PARITY_FAULT 2
`define LS_STOP_BIT_ERROR 3
`define LS_BREAK_SEEN 4
`define LS_TX_HOLDING_EMPTY 5
`define LS_TX_ALL_EMPTY 6
`define LS_FIFO_ERROR_SUMMARY 7

`define IRQ_TX_HOLDING_EMPTY 0
`define IRQ_LINE_ERROR 1
`define IRQ_RX_DATA 2

`define FIFO_DEPTH 6'd32
`define CHAR_DEPTH 6'd1

`define RST_CONTROL 8'h00
`define RST_IRQ_MASK 3'h0

`endif

// ---- verif/uart_lsr_monitor.sv ----
// Purpose: Port assertions of the line-status block
// Assumes: One clock, async active-high reset
// Notes: Bind sits after endmodule
`timescale 1ns/1ps
`include "uart_lsr_consts.vh"
module uart_lsr_monitor (
    input wire sysClk, // Clock
    input wire sysRst, // Reset
    input wire [7:0] paddr, // Address
    input wire psel, // Select
    input wire penable, // Enable
    input wire pwrite, // Direction
    input wire [31:0] prdata, // Read data
    input wire pready, // Ready
    input wire pslverr, // Error
    input wire txLoad, // Load pulse
    input wire [7:0] txData, // Character
    input wire txShiftBusy // Shifter busy
);
    default clocking @(posedge sysClk); endclocking
    default disable iff (sysRst);
    wire lsRead = pready && !pwrite && paddr == `ADDR_LINE_STATUS && !pslverr;
    ready_wait_a: assert property (psel && penable && !pready |=> pready) else $error("ready late");
    ready_phase_a: assert property (pready |-> psel && penable && $past(psel && penable)) else $error("ready early");
    bad_addr_a: assert property (pready && (paddr > 8'h10 || paddr[1:0] != 2'h0) |-> pslverr) else $error("no error");
    load_pulse_a: assert property (txLoad |=> !txLoad) else $error("load too long");
    load_idle_a: assert property (txLoad |-> !$past(txShiftBusy)) else $error("load while busy");
    data_hold_a: assert property (!txLoad |-> $stable(txData)) else $error("character moved");
    empty_order_a: assert property (lsRead && prdata[6] |-> prdata[5]) else $error("empty flags");
    busy_full_a: assert property (lsRead && $past(txShiftBusy) |-> !prdata[6]) else $error("busy empty");
    load_full_a: assert property (lsRead && $past(txLoad) |-> !prdata[6]) else $error("load empty");
    cover property (lsRead && prdata[6]);
    cover property (txLoad);
    cover property (pready && pslverr);
endmodule // uart_lsr_monitor
bind uart_line_status_flags uart_lsr_monitor mon (.sysClk, .sysRst, .paddr, .psel, .penable, .pwrite, .prdata,
    .pready, .pslverr, .txLoad, .txData, .txShiftBusy);

// ---- verif/serial_far_end.sv ----
// Purpose: Serializer and deserializer model beside the block
// Assumes: Shifter busy rises the cycle after a load
// Notes: Idle data lines show the inverse of the last value
`timescale 1ns/1ps
module serial_far_end (
    input wire sysClk, // Clock
    input wire sysRst, // Reset
    input wire txLoad, // Load pulse
    input wire slow, // Long shift time
    output logic txShiftBusy, // Shifter busy
    output logic rxValid, // Character pulse
    output logic [7:0] rxData, // Character
    output logic rxParityErr, // Parity flag
    output logic rxFrameErr, // Stop flag
    output logic rxBreak, // Break flag
    output logic rxLine // Line level
);
    logic [5:0] left;
    initial begin
        rxValid = 1'b0;
        {rxData, rxParityErr, rxFrameErr, rxBreak, rxLine} = 12'h001;
    end
    always @(posedge sysClk or posedge sysRst) begin
        if (sysRst) begin
            left <= 6'h00;
            txShiftBusy <= 1'b0;
        end else if (txLoad) begin
            left <= slow ? 6'h1e : 6'h02;
            txShiftBusy <= 1'b1;
        end else if (left > 6'h01) begin
            left <= left - 6'h01;
        end else begin
            left <= 6'h00;
            txShiftBusy <= 1'b0;
        end
    end
    task automatic send(input logic [7:0] d, input logic p, input logic f, input logic b);
        begin
            @(posedge sysClk);
            rxValid <= 1'b1;
            {rxData, rxParityErr, rxFrameErr, rxBreak} <= {d, p, f, b};
            rxLine <= !b;
            @(posedge sysClk);
            rxValid <= 1'b0;
            {rxData, rxParityErr, rxFrameErr, rxBreak} <= ~{d, p, f, b};
        end
    endtask
endmodule // serial_far_end

// ---- verif/tb_top.sv ----
// Purpose: Register-level tests of the line-status block
// Assumes: One wait state APB slave
// Notes: Slow shifter keeps characters queued for a while
`timescale 1ns/1ps
`include "uart_lsr_consts.vh"
module tb_top;
    logic sysClk, sysRst, psel, penable, pwrite, slow, rdErr;
    logic [7:0] paddr;
    logic [31:0] pwdata, rdVal;
    wire [31:0] prdata;
    wire [7:0] txData, rxData;
    wire pready, pslverr, irq, txLoad, txShiftBusy, rxValid, rxParityErr, rxFrameErr, rxBreak, rxLine;
    int errTotal = 0;
    int totalChecks = 0;
    int cycles = 0;
    uart_line_status_flags uut (.sysClk, .sysRst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .irq, .txLoad, .txData, .txShiftBusy, .rxValid, .rxData, .rxParityErr, .rxFrameErr, .rxBreak, .rxLine);
    serial_far_end far (.sysClk, .sysRst, .txLoad, .slow, .txShiftBusy, .rxValid, .rxData, .rxParityErr,
        .rxFrameErr, .rxBreak, .rxLine);
    initial begin
        sysClk = 1'b0;
        forever #12.5 sysClk = ~sysClk;
    end
    task automatic wrapUp;
        begin
            $display("checks %0d mismatches %0d", totalChecks, errTotal);
            if (errTotal == 0 && totalChecks > 0) begin
                $display("All checks passed");
            end else begin
                $display("Checks failed");
            end
            $finish;
        end
    endtask
    // Whole run needs well under this
    always @(posedge sysClk) begin
        cycles++;
        if (cycles == 6000) begin
            errTotal++;
            $display("[FAIL] %0t timeout", $time);
            wrapUp;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            totalChecks++;
            if (got !== exp) begin
                errTotal++;
                $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        begin
            @(posedge sysClk);
            {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
            @(posedge sysClk);
            penable <= 1'b1;
            do @(posedge sysClk); while (pready !== 1'b1);
            rdVal = prdata;
            rdErr = pslverr;
            {psel, penable} <= 2'b00;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        begin
            apb(1'b0, a, 32'h0);
            chk(rdVal, exp);
        end
    endtask
    task automatic irqIs(input logic v);
        begin
            @(negedge sysClk);
            chk({31'h0, irq}, {31'h0, v});
        end
    endtask
    task automatic waitLs(input logic [31:0] v);
        int k;
        begin
            for (k = 0; k < 60 && rdVal !== v; k++) apb(1'b0, `ADDR_LINE_STATUS, 32'h0);
            chk(rdVal, v);
        end
    endtask
    initial begin
        {sysRst, psel, penable, pwrite, paddr, pwdata, slow} = {4'h8, 8'h00, 32'h0, 1'b1};
        repeat (10) @(posedge sysClk);
        sysRst <= 1'b0;
        rd(`ADDR_LINE_STATUS, 32'h60);
        rd(`ADDR_IRQ_MASK, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk({31'h0, rdErr}, 32'h1);
        apb(1'b1, `ADDR_DATA, 32'h41);
        rd(`ADDR_LINE_STATUS, 32'h20);
        apb(1'b1, `ADDR_DATA, 32'h42);
        apb(1'b1, `ADDR_DATA, 32'h43);
        rd(`ADDR_LINE_STATUS, 32'h00);
        waitLs(32'h60);
        rd(`ADDR_IRQ_STATUS, 32'h1);
        irqIs(1'b0);
        apb(1'b1, `ADDR_IRQ_MASK, 32'h1);
        irqIs(1'b1);
        apb(1'b1, `ADDR_IRQ_STATUS, 32'h1);
        irqIs(1'b0);
        far.send(8'h55, 1'b0, 1'b1, 1'b0);
        rd(`ADDR_LINE_STATUS, 32'h69);
        rd(`ADDR_DATA, 32'h55);
        far.send(8'h61, 1'b0, 1'b0, 1'b0);
        far.send(8'h62, 1'b1, 1'b0, 1'b0);
        rd(`ADDR_LINE_STATUS, 32'h63);
        rd(`ADDR_LINE_STATUS, 32'h61);
        rd(`ADDR_DATA, 32'h61);
        apb(1'b1, `ADDR_CONTROL, 32'h1);
        far.send(8'h11, 1'b1, 1'b0, 1'b0);
        far.send(8'h22, 1'b0, 1'b0, 1'b0);
        rd(`ADDR_LINE_STATUS, 32'he5);
        rd(`ADDR_LINE_STATUS, 32'h65);
        rd(`ADDR_DATA, 32'h11);
        rd(`ADDR_LINE_STATUS, 32'h61);
        rd(`ADDR_DATA, 32'h22);
        far.send(8'h00, 1'b0, 1'b1, 1'b1);
        far.send(8'h00, 1'b0, 1'b1, 1'b1);
        rd(`ADDR_LINE_STATUS, 32'hf9);
        rd(`ADDR_DATA, 32'h00);
        rd(`ADDR_LINE_STATUS, 32'h60);
        apb(1'b1, `ADDR_DATA, 32'h31);
        apb(1'b1, `ADDR_DATA, 32'h32);
        rd(`ADDR_LINE_STATUS, 32'h00);
        slow <= 1'b0;
        waitLs(32'h60);
        wrapUp;
    end
endmodule // tb_top
